// ---- ddcr_gain_if.sv ----
// Control link between the register bank and the band-0 gain stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface ddcr_gain_if;
    logic double_gain;
    logic wide_path;

    modport ctrl (output double_gain, output wide_path);
    modport stage (input double_gain, input wide_path);
endinterface : ddcr_gain_if
`default_nettype wire

// ---- ddcr_gain_stage.sv ----
// Band-0 output scaler: optional doubling with saturation.
// Assumes samples are signed two's complement, one per valid cycle.
`timescale 1ns/1ps
`default_nettype none
module ddcr_gain_stage
    import ddcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    ddcr_gain_if.stage ctl,
    // Sample in
    input wire logic in_valid,
    input wire logic signed [SAMPLE_W-1:0] in_i,
    input wire logic signed [SAMPLE_W-1:0] in_q,
    // Sample out
    output logic out_valid,
    output logic signed [SAMPLE_W-1:0] out_i,
    output logic signed [SAMPLE_W-1:0] out_q
);

    typedef struct packed {
        logic valid;
        logic signed [SAMPLE_W-1:0] i;
        logic signed [SAMPLE_W-1:0] q;
    } ddcr_gain_state_t;

    ddcr_gain_state_t st_reg;
    ddcr_gain_state_t st_next;

    // Doubling saturates rather than wraps, so a full-scale input stays sane
    function automatic logic signed [SAMPLE_W-1:0] dbl(input logic signed [SAMPLE_W-1:0] x);
        logic [1:0] top;
        top = x[SAMPLE_W-1 -: 2];
        if (top == 2'b01)
            dbl = {1'b0, {(SAMPLE_W-1){1'b1}}};
        else if (top == 2'b10)
            dbl = {1'b1, {(SAMPLE_W-1){1'b0}}};
        else
            dbl = {x[SAMPLE_W-2:0], 1'b0};
    endfunction

    // Scale only on the narrow path
    always_comb
    begin
        st_next = st_reg;
        st_next.valid = in_valid;
        if (in_valid)
        begin
            if (ctl.double_gain && !ctl.wide_path)
            begin
                st_next.i = dbl(in_i);
                st_next.q = dbl(in_q);
            end
            else
            begin
                st_next.i = in_i;
                st_next.q = in_q;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign out_valid = st_reg.valid;
    assign out_i = st_reg.i;
    assign out_q = st_reg.q;

endmodule // ddcr_gain_stage
`default_nettype wire

// ---- ddcr_pkg.sv ----
// Constants and types for the down-converter control register group.
// Assumes one system clock; all inputs except the asynchronous reset are synchronous to it.
// How it works
// - Choice 00/01/10 picks oscillator one/two/three
// - Register choice field sits in bits 1-0
// - Pin-select bit 1 takes choice from pins
// - Policy 00: reset on every frame reset
// - Policy 01: first after start, then resync
// - Policy 10: resync applies two frame resets
// - Policy 11: reset only on converter start
// - Gain bit doubles band-0 output
// - Wide filter path never gets this doubling
package ddcr_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CHOICE_BY_PINS = 8'h0F;
    localparam logic [7:0] ADDR_OSC_CHOICE = 8'h10;
    localparam logic [7:0] ADDR_RESET_POLICY = 8'h11;
    localparam logic [7:0] ADDR_BAND0_GAIN = 8'h14;

    // Reset values
    localparam logic [1:0] OSC_CHOICE_RESET = 2'h0;
    localparam logic [1:0] RESET_POLICY_RESET = 2'h0;
    localparam logic BY_PINS_RESET = 1'b0;
    localparam logic GAIN_RESET = 1'b0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Field positions
    localparam int CHOICE_LSB = 0;
    localparam int POLICY_LSB = 0;
    localparam int FLAG_BIT = 0;

    // Oscillator choice codes
    localparam logic [1:0] OSC_ONE = 2'h0;
    localparam logic [1:0] OSC_TWO = 2'h1;
    localparam logic [1:0] OSC_THREE = 2'h2;

    // Frame reset policy codes
    localparam logic [1:0] POLICY_EVERY = 2'h0;
    localparam logic [1:0] POLICY_ONCE_RESYNC = 2'h1;
    localparam logic [1:0] POLICY_TWICE_RESYNC = 2'h2;
    localparam logic [1:0] POLICY_START_ONLY = 2'h3;

    // Sample width
    localparam int SAMPLE_W = 16;

    // Reset sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_ARMED = 5'b0_0010,
        ST_RUN = 5'b0_0100,
        ST_WAIT_TWO = 5'b0_1000,
        ST_WAIT_ONE = 5'b1_0000
    } ddcr_state_t;

endpackage : ddcr_pkg

// ---- ddcr_top.sv ----
// Register bank for oscillator choice, frame reset policy and band-0 gain.
// Assumes a simple synchronous register port from the serial control logic
// and single-cycle event pulses from the link and clock logic.
// Map: 0x0F pin-select, 0x10 oscillator choice, 0x11 reset policy,
// 0x14 band-0 gain; other addresses read zero and ignore writes.
// Reset is asynchronous and clears every field except the sequencer, which starts idle.
`timescale 1ns/1ps
`default_nettype none
module ddcr_top
    import ddcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    // Oscillator selection
    input wire logic [1:0] gpio_osc_choice,
    output logic [1:0] osc_active,
    // Reset policy events
    input wire logic frame_reset_event,
    input wire logic ddc_start,
    input wire logic clk_div_resync,
    output logic ddc_nco_reset,
    // Band-0 samples
    input wire logic wide_path_active,
    input wire logic band0_in_valid,
    input wire logic signed [SAMPLE_W-1:0] band0_in_i,
    input wire logic signed [SAMPLE_W-1:0] band0_in_q,
    output logic band0_out_valid,
    output logic signed [SAMPLE_W-1:0] band0_out_i,
    output logic signed [SAMPLE_W-1:0] band0_out_q
);

    // All state of the bank in one record: host fields first, then the
    // derived outputs and the sequencer, so one flop group holds it all
    typedef struct packed {
        // Host-written control fields
        logic by_pins;
        logic [1:0] osc_choice;
        logic [1:0] reset_policy;
        logic band0_double_gain;
        // Registered selection and start edge detector
        logic [1:0] osc_active;
        logic start_seen;
        // Reset pulse and the policy sequencer behind it
        logic nco_reset;
        ddcr_state_t seq;
        // Readback word, one cycle behind the address
        logic [7:0] rdata;
    } ddcr_top_state_t;

    // Every field starts cleared; the sequencer starts idle and the
    // first policy-00 cycle moves it to the running state
    localparam ddcr_top_state_t ST_RESET_VALUE = '{
        by_pins: BY_PINS_RESET,
        osc_choice: OSC_CHOICE_RESET,
        reset_policy: RESET_POLICY_RESET,
        band0_double_gain: GAIN_RESET,
        osc_active: OSC_ONE,
        start_seen: 1'b0,
        nco_reset: 1'b0,
        seq: ST_IDLE,
        rdata: RDATA_RESET
    };

    // Current and next copy of the record
    ddcr_top_state_t st_reg;
    ddcr_top_state_t st_next;

    // Decoded helpers shared by the next-state logic
    logic [1:0] choice_src;
    logic start_rise;

    // Control link to the band-0 scaler
    ddcr_gain_if gain_link ();

    // Source of the oscillator choice; pins are taken as already
    // synchronous, so no extra flop delays a pin-driven hop
    assign choice_src = st_reg.by_pins ? gpio_osc_choice : st_reg.osc_choice;

    // Start is a level; only its rising edge restarts a policy, so a start
    // held high for many cycles gives one restart, not a stream of them
    assign start_rise = ddc_start && !st_reg.start_seen;

    // Next state: register writes, readback, oscillator decode and the
    // reset-policy sequencer, all from the current record and the inputs
    always_comb
    begin
        // Hold by default; the reset pulse is cleared every cycle, so it
        // stands for exactly one cycle after the event that raised it
        st_next = st_reg;
        st_next.start_seen = ddc_start;
        st_next.nco_reset = 1'b0;

        // Register writes; upper bits are dropped, host keeps them zero
        if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_CHOICE_BY_PINS: st_next.by_pins = reg_wdata[FLAG_BIT];
                ADDR_OSC_CHOICE: st_next.osc_choice = reg_wdata[CHOICE_LSB +: 2];
                ADDR_RESET_POLICY: st_next.reset_policy = reg_wdata[POLICY_LSB +: 2];
                ADDR_BAND0_GAIN: st_next.band0_double_gain = reg_wdata[FLAG_BIT];
                default: ;
            endcase
        end

        // Readback, one cycle late; unused bits read zero
        // No read strobe, so a read never disturbs any state
        unique case (reg_addr)
            ADDR_CHOICE_BY_PINS: st_next.rdata = {7'h00, st_reg.by_pins};
            ADDR_OSC_CHOICE: st_next.rdata = {6'h00, st_reg.osc_choice};
            ADDR_RESET_POLICY: st_next.rdata = {6'h00, st_reg.reset_policy};
            ADDR_BAND0_GAIN: st_next.rdata = {7'h00, st_reg.band0_double_gain};
            default: st_next.rdata = RDATA_RESET;
        endcase

        // Decode the choice; undefined code 11 keeps the last oscillator
        // Holding beats a fallback: a stray code never hops the mixer phase
        unique case (choice_src)
            OSC_ONE: st_next.osc_active = OSC_ONE;
            OSC_TWO: st_next.osc_active = OSC_TWO;
            OSC_THREE: st_next.osc_active = OSC_THREE;
            default: st_next.osc_active = st_reg.osc_active;
        endcase

        // Reset sequencer; under policies 01 and 10 a converter start restarts the sequence in any state
        // Policies 00 and 11 are stateless and park the sequencer in RUN; 01 and 10
        // arm on a start, pulse on the next frame event, then wait in RUN for a
        // divider resync. A resync that lands while a wait is pending is dropped,
        // since the pending frame event realigns the converters anyway.
        unique case (st_reg.reset_policy)
            POLICY_EVERY:
            begin
                st_next.nco_reset = frame_reset_event;
                st_next.seq = ST_RUN;
            end
            POLICY_START_ONLY:
            begin
                st_next.nco_reset = start_rise;
                st_next.seq = ST_RUN;
            end
            default:
            begin
                if (start_rise)
                    st_next.seq = ST_ARMED;
                else
                begin
                    unique case (st_reg.seq)
                        // No start seen yet: frame events are ignored
                        ST_IDLE: ;
                        // Started: the next frame event gives the first reset
                        ST_ARMED:
                            if (frame_reset_event)
                            begin
                                st_next.nco_reset = 1'b1;
                                st_next.seq = ST_RUN;
                            end
                        // Running: only a divider resync opens a new window
                        ST_RUN:
                            if (clk_div_resync)
                                st_next.seq = (st_reg.reset_policy == POLICY_TWICE_RESYNC)
                                    ? ST_WAIT_TWO : ST_WAIT_ONE;
                        // Two frame events still owed after a resync
                        ST_WAIT_TWO:
                            if (frame_reset_event)
                            begin
                                st_next.nco_reset = 1'b1;
                                st_next.seq = ST_WAIT_ONE;
                            end
                        // Last frame event owed after a resync
                        ST_WAIT_ONE:
                            if (frame_reset_event)
                            begin
                                st_next.nco_reset = 1'b1;
                                st_next.seq = ST_RUN;
                            end
                        default: st_next.seq = ST_IDLE;
                    endcase
                end
            end
        endcase
    end

    // One flop group for the whole record; the asynchronous reset keeps
    // the reset pulse low from power-up, before the clock is running,
    // so the converters never see a spurious restart
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            st_reg <= ST_RESET_VALUE;
        else
            st_reg <= st_next;
    end

    // Gain control to the band-0 stage
    assign gain_link.double_gain = st_reg.band0_double_gain;
    assign gain_link.wide_path = wide_path_active;

    // The scaler owns the sample flops; this bank only steers it,
    // so sample latency does not depend on register traffic
    ddcr_gain_stage u_gain (
        .clk_sys(clk_sys),
        .reset(reset),
        .ctl(gain_link.stage),
        .in_valid(band0_in_valid),
        .in_i(band0_in_i),
        .in_q(band0_in_q),
        .out_valid(band0_out_valid),
        .out_i(band0_out_i),
        .out_q(band0_out_q)
    );

    // Outputs straight from the record, so every data output is a flop
    assign reg_rdata = st_reg.rdata;
    assign osc_active = st_reg.osc_active;
    assign ddc_nco_reset = st_reg.nco_reset;

endmodule // ddcr_top
`default_nettype wire

// ---- ddcr_top_asserts.sv ----
// Port checker for the down-converter control register group.
// Assumes a mirror of host writes; bound onto ddcr_top.
`timescale 1ns/1ps
`default_nettype none
module ddcr_top_asserts
    import ddcr_pkg::*;
(
    // Clock and register port
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    // Selection and events
    input wire logic [1:0] gpio_osc_choice,
    input wire logic [1:0] osc_active,
    input wire logic frame_reset_event,
    input wire logic ddc_start,
    input wire logic clk_div_resync,
    input wire logic ddc_nco_reset,
    // Samples
    input wire logic wide_path_active,
    input wire logic band0_in_valid,
    input wire logic signed [SAMPLE_W-1:0] band0_in_i,
    input wire logic signed [SAMPLE_W-1:0] band0_in_q,
    input wire logic band0_out_valid,
    input wire logic signed [SAMPLE_W-1:0] band0_out_i,
    input wire logic signed [SAMPLE_W-1:0] band0_out_q
);
    logic pin_reg, gain_reg, start_reg, rise, dbl;
    logic [1:0] osc_reg, pol_reg;
    logic [7:0] rd_exp;
    // Mirror keeps only the low field bits, as the bank does
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {pin_reg, gain_reg, start_reg, osc_reg, pol_reg} <= '0;
        else
        begin
            start_reg <= ddc_start;
            if (reg_wr && reg_addr == ADDR_CHOICE_BY_PINS) pin_reg <= reg_wdata[0];
            if (reg_wr && reg_addr == ADDR_OSC_CHOICE) osc_reg <= reg_wdata[1:0];
            if (reg_wr && reg_addr == ADDR_RESET_POLICY) pol_reg <= reg_wdata[1:0];
            if (reg_wr && reg_addr == ADDR_BAND0_GAIN) gain_reg <= reg_wdata[0];
        end
    end
    // Expected readback; unmapped places read zero
    assign rd_exp = reg_addr == ADDR_CHOICE_BY_PINS ? {7'h0, pin_reg} :
        reg_addr == ADDR_OSC_CHOICE ? {6'h0, osc_reg} :
        reg_addr == ADDR_RESET_POLICY ? {6'h0, pol_reg} :
        reg_addr == ADDR_BAND0_GAIN ? {7'h0, gain_reg} : 8'h00;
    assign rise = ddc_start && !start_reg;
    assign dbl = gain_reg && !wide_path_active;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_reg_src;
        !pin_reg && osc_reg != 2'h3;
    endsequence
    sequence s_small_in;
        band0_in_valid && dbl && band0_in_i[15] == band0_in_i[14] && band0_in_q[15] == band0_in_q[14];
    endsequence
    a_reg_choice: assert property (s_reg_src |=> osc_active == $past(osc_reg))
        else $error("oscillator not taken from register");
    a_pin_choice: assert property (pin_reg && gpio_osc_choice != 2'h3 |=> osc_active == $past(gpio_osc_choice))
        else $error("oscillator not taken from pins");
    a_undef_hold: assert property ((pin_reg ? gpio_osc_choice : osc_reg) == 2'h3 |=> $stable(osc_active))
        else $error("undefined code changed oscillator");
    a_read_back: assert property (1'b1 |=> reg_rdata == $past(rd_exp))
        else $error("readback wrong");
    a_every_frame: assert property (pol_reg == POLICY_EVERY |=> ddc_nco_reset == $past(frame_reset_event))
        else $error("policy every: reset pulse wrong");
    a_start_only: assert property (pol_reg == POLICY_START_ONLY |=> ddc_nco_reset == $past(rise))
        else $error("policy start: reset pulse wrong");
    a_resync_quiet: assert property (pol_reg inside {2'h1, 2'h2} && !frame_reset_event |=> !ddc_nco_reset)
        else $error("reset pulse without frame event");
    a_plain_pass: assert property (band0_in_valid && !dbl |=> band0_out_valid
        && band0_out_i == $past(band0_in_i) && band0_out_q == $past(band0_in_q))
        else $error("sample altered without gain");
    a_double_gain: assert property (s_small_in |=> band0_out_valid
        && band0_out_i == ($past(band0_in_i) <<< 1) && band0_out_q == ($past(band0_in_q) <<< 1))
        else $error("sample not doubled");
endmodule // ddcr_top_asserts
bind ddcr_top ddcr_top_asserts chk_u (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
    .gpio_osc_choice, .osc_active, .frame_reset_event, .ddc_start, .clk_div_resync, .ddc_nco_reset,
    .wide_path_active, .band0_in_valid, .band0_in_i, .band0_in_q, .band0_out_valid, .band0_out_i, .band0_out_q);
`default_nettype wire

// ---- ddcr_top_tb.sv ----
// Self-checking bench for the down-converter control register group.
// Assumes the checker is bound in; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ddcr_top_tb
    import ddcr_pkg::*;
;
    logic clk_sys = 0, reset = 1, reg_wr = 0, frame_reset_event = 0, ddc_start = 0, clk_div_resync = 0;
    logic wide_path_active = 0, band0_in_valid = 0, ddc_nco_reset, band0_out_valid;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [1:0] gpio_osc_choice = 0, osc_active;
    logic signed [SAMPLE_W-1:0] band0_in_i = 0, band0_in_q = 0, band0_out_i, band0_out_q;
    logic [7:0] regs[5] = '{ADDR_CHOICE_BY_PINS, ADDR_OSC_CHOICE, ADDR_RESET_POLICY, ADDR_BAND0_GAIN, 8'h12};
    int mismatches = 0, n_checks = 0, cyc = 0;
    int pq[$];
    logic [31:0] sq[$];
    ddcr_top dut_u (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .gpio_osc_choice,
        .osc_active, .frame_reset_event, .ddc_start, .clk_div_resync, .ddc_nco_reset, .wide_path_active,
        .band0_in_valid, .band0_in_i, .band0_in_q, .band0_out_valid, .band0_out_i, .band0_out_q);
    // Clock and cycle count used to time expected pulses
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        tick();
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        tick();
        chk(reg_rdata, e);
    endtask
    task automatic osc(input logic [1:0] e);
        tick(2);
        chk(osc_active, e);
    endtask
    // One event: f frame, r resync, s start; upper case expects a pulse
    // The event is taken at the next edge and the pulse is seen right after it
    task automatic ev(input byte c);
        if (c < "a") pq.push_back(cyc + 1);
        frame_reset_event = (c == "f" || c == "F");
        clk_div_resync = (c == "r");
        ddc_start = (c == "s" || c == "S");
        tick();
        {frame_reset_event, clk_div_resync, ddc_start} = 3'h0;
        tick();
    endtask
    task automatic seqn(input logic [7:0] p, input string s);
        wr(ADDR_RESET_POLICY, p);
        foreach (s[k]) ev(s[k]);
    endtask
    function automatic logic [15:0] sat2(input logic signed [15:0] x);
        if (x > 16'sh3FFF) return 16'h7FFF;
        if (x < 16'shC000) return 16'h8000;
        return x <<< 1;
    endfunction
    task automatic samples(input logic g);
        logic signed [15:0] i, q;
        logic w;
        wr(ADDR_BAND0_GAIN, {7'h0, g});
        repeat (24)
        begin
            i = 16'($urandom);
            q = 16'($urandom);
            w = 1'($urandom);
            band0_in_valid = 1;
            band0_in_i = i;
            band0_in_q = q;
            wide_path_active = w;
            sq.push_back((g && !w) ? {sat2(i), sat2(q)} : {i, q});
            tick();
        end
        band0_in_valid = 0;
        tick(2);
    endtask
    // Monitor: every pulse or sample takes the oldest note
    always @(negedge clk_sys)
    begin
        if (!reset && ddc_nco_reset)
            chk(pq.size() ? pq.pop_front() : -1, cyc);
        if (!reset && band0_out_valid)
            chk(sq.size() ? sq.pop_front() : 32'hX, {band0_out_i, band0_out_q});
    end
    // Hang guard
    initial
    begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'h22e6));
        tick(5);
        reset = 0;
        foreach (regs[k]) rd(regs[k], 8'h00);
        seqn(8'h01, "frFsFfrFf");
        seqn(8'h02, "sFfrFFf");
        seqn(8'h03, "fSfrS");
        seqn(8'h00, "FrsF");
        // Back-to-back frame events each give a pulse
        repeat (3)
        begin
            pq.push_back(cyc + 1);
            frame_reset_event = 1;
            tick();
        end
        frame_reset_event = 0;
        for (int c = 0; c < 3; c++)
        begin
            wr(ADDR_OSC_CHOICE, 8'(c));
            osc(2'(c));
            rd(ADDR_OSC_CHOICE, 8'(c));
        end
        wr(ADDR_OSC_CHOICE, 8'hFD);
        osc(2'h1);
        rd(ADDR_OSC_CHOICE, 8'h01);
        wr(ADDR_OSC_CHOICE, 8'h03);
        osc(2'h1);
        wr(8'h12, 8'hFF);
        rd(8'h12, 8'h00);
        wr(ADDR_CHOICE_BY_PINS, 8'h01);
        repeat (6)
        begin
            gpio_osc_choice = 2'($urandom % 3);
            osc(gpio_osc_choice);
        end
        wr(ADDR_CHOICE_BY_PINS, 8'h00);
        osc(gpio_osc_choice);
        samples(1'b0);
        samples(1'b1);
        for (int k = 0; k < 20 && (pq.size() || sq.size()); k++) tick();
        if (pq.size() || sq.size()) chk(1, 0);
        stop_test();
    end
endmodule // ddcr_top_tb
`default_nettype wire
